/* File: logic/gpem_gpio_edge.v */
// Four 8-bit ports with edge interrupts and mirrored clear/protect logic, AXI4-Lite slave
//
// The register addresses and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/1ps
`include "gpem_regs.vh"

module gpem_gpio_edge (
   input wire aclk,
   input wire aresetn,
   input wire [7:0] s_axi_awaddr,
   input wire [2:0] s_axi_awprot,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [7:0] s_axi_araddr,
   input wire [2:0] s_axi_arprot,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   input wire [31:0] pin_in,
   output reg [31:0] pin_out,
   output reg [31:0] pin_oe_n,
   output reg irq_req,
   output reg [7:0] interrupt_vector_address
);

   reg aw_held;
   reg w_held;
   reg [7:0] aw_addr;
   reg [31:0] w_data;
   reg [3:0] w_strb;
   reg [127:0] mode_all;
   reg [31:0] data_q;
   reg [31:0] pend_q;
   reg [31:0] level_q;
   wire [31:0] is_edge;
   wire [31:0] pin_rise;
   wire [31:0] pin_fall;
   wire do_write;
   reg [3:0] wr_data_port;
   reg [3:0] wr_mode_port;
   reg wr_hit;
   reg [31:0] next_rdata;
   reg rd_hit;
   reg [7:0] next_vector;
   reg found;

   // Bus handshakes: one write and one read at a time
   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready = !w_held && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;
   assign do_write = aw_held && w_held && !s_axi_bvalid;

   // Address and data capture, either order
   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 8'h00;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end else if (do_write) begin
            aw_held <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end else if (do_write) begin
            w_held <= 1'b0;
         end
      end
   end

   // Write decode per port window
   always @* begin : wr_dec
      integer p;
      p = 0;
      wr_data_port = 4'h0;
      wr_mode_port = 4'h0;
      wr_hit = 1'b0;
      for (p = 0; p < `GPEM_NUM_PORTS; p = p + 1) begin
         if (aw_addr == p * `GPEM_PORT_STRIDE + `GPEM_OFF_DATA) begin
            wr_data_port[p] = do_write && w_strb[0];
            wr_hit = 1'b1;
         end else if (aw_addr == p * `GPEM_PORT_STRIDE + `GPEM_OFF_MODE) begin
            wr_mode_port[p] = do_write;
            wr_hit = 1'b1;
         end else if (aw_addr == p * `GPEM_PORT_STRIDE + `GPEM_OFF_PEND) begin
            wr_hit = 1'b1;
         end else if (aw_addr == p * `GPEM_PORT_STRIDE + `GPEM_OFF_LEVEL) begin
            wr_hit = 1'b1;
         end
      end
   end

   // Write response
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `GPEM_RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_hit ? `GPEM_RESP_OKAY : `GPEM_RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Mode registers, byte enables honoured
   always @(posedge aclk) begin : mode_wr
      integer p;
      integer k;
      if (!aresetn) begin
         mode_all <= `GPEM_MODE_RESET;
      end else begin
         for (p = 0; p < `GPEM_NUM_PORTS; p = p + 1) begin
            for (k = 0; k < 4; k = k + 1) begin
               if (wr_mode_port[p] && w_strb[k]) begin
                  mode_all[p * 32 + k * 8 +: 8] <= w_data[k * 8 +: 8];
               end
            end
         end
      end
   end

   // Previous pin level for edge detection
   always @(posedge aclk) begin
      if (!aresetn) begin
         level_q <= 32'h0000_0000;
      end else begin
         level_q <= pin_in;
      end
   end

   assign pin_rise = pin_in & ~level_q;
   assign pin_fall = ~pin_in & level_q;

   // Per pin: edge mode, data bit, pending flag, pin drive
   genvar i;
   generate
      for (i = 0; i < `GPEM_NUM_PINS; i = i + 1) begin : g_pin
         localparam integer MIR = i ^ 7;
         wire [3:0] mode = mode_all[i * 4 +: 4];
         wire edge_hit;
         wire mir_clear;
         assign is_edge[i] = (mode == `GPEM_MODE_DUAL_EDGE) || (mode == `GPEM_MODE_SINGLE_EDGE);
         // dual, or rising/falling by data bit
         assign edge_hit = (mode == `GPEM_MODE_DUAL_EDGE) ? (pin_rise[i] | pin_fall[i]) :
            (mode == `GPEM_MODE_SINGLE_EDGE) ? (data_q[i] ? pin_rise[i] : pin_fall[i]) : 1'b0;
         assign mir_clear = wr_data_port[i / 8] && w_data[i % 8] && is_edge[MIR];

         always @(posedge aclk) begin
            if (!aresetn) begin
               data_q[i] <= `GPEM_DATA_RESET;
            end else if (wr_data_port[i / 8] && !is_edge[MIR]) begin
               data_q[i] <= w_data[i % 8];
            end
         end

         always @(posedge aclk) begin
            if (!aresetn) begin
               pend_q[i] <= 1'b0;
            end else if (edge_hit) begin
               pend_q[i] <= 1'b1;
            end else if (mir_clear) begin
               pend_q[i] <= 1'b0;
            end
         end

         // Output drive for output mode only
         always @(posedge aclk) begin
            if (!aresetn) begin
               pin_out[i] <= 1'b0;
               pin_oe_n[i] <= 1'b1;
            end else begin
               pin_out[i] <= data_q[i];
               pin_oe_n[i] <= (mode != `GPEM_MODE_OUTPUT);
            end
         end
      end
   endgenerate

   // Read decode
   always @* begin : rd_dec
      integer p;
      p = 0;
      next_rdata = 32'h0000_0000;
      rd_hit = 1'b0;
      for (p = 0; p < `GPEM_NUM_PORTS; p = p + 1) begin
         if (s_axi_araddr == p * `GPEM_PORT_STRIDE + `GPEM_OFF_DATA) begin
            next_rdata = {24'h000000, data_q[p * 8 +: 8]};
            rd_hit = 1'b1;
         end else if (s_axi_araddr == p * `GPEM_PORT_STRIDE + `GPEM_OFF_MODE) begin
            next_rdata = mode_all[p * 32 +: 32];
            rd_hit = 1'b1;
         end else if (s_axi_araddr == p * `GPEM_PORT_STRIDE + `GPEM_OFF_PEND) begin
            next_rdata = {24'h000000, pend_q[p * 8 +: 8]};
            rd_hit = 1'b1;
         end else if (s_axi_araddr == p * `GPEM_PORT_STRIDE + `GPEM_OFF_LEVEL) begin
            next_rdata = {24'h000000, level_q[p * 8 +: 8]};
            rd_hit = 1'b1;
         end
      end
   end

   // Read channel
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `GPEM_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= next_rdata;
         s_axi_rresp <= rd_hit ? `GPEM_RESP_OKAY : `GPEM_RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // vector from own pin index only
   always @* begin : vec_sel
      integer k;
      k = 0;
      next_vector = 8'h00;
      found = 1'b0;
      for (k = 0; k < `GPEM_NUM_PINS; k = k + 1) begin
         if (pend_q[k] && !found) begin
            next_vector = `GPEM_VEC_BASE + (k[7:0] << `GPEM_VEC_STEP_SHIFT);
            found = 1'b1;
         end
      end
   end

   // Request and vector registers
   always @(posedge aclk) begin
      if (!aresetn) begin
         irq_req <= 1'b0;
         interrupt_vector_address <= 8'h00;
      end else begin
         irq_req <= found;
         interrupt_vector_address <= next_vector;
      end
   end

endmodule

/* File: logic/gpem_regs.vh */
// Register map, field codes and fixed values of the edge interrupt port block
`ifndef GPEM_REGS_VH
`define GPEM_REGS_VH

`define GPEM_NUM_PORTS 4
`define GPEM_PINS_PER_PORT 8
`define GPEM_NUM_PINS 32
`define GPEM_MODE_W 4

// Byte offsets inside one port window, window stride 0x10
`define GPEM_PORT_STRIDE 8'h10
`define GPEM_OFF_DATA 4'h0
`define GPEM_OFF_MODE 4'h4
`define GPEM_OFF_PEND 4'h8
`define GPEM_OFF_LEVEL 4'hc
`define GPEM_ADDR_W 8

// Pin mode codes
`define GPEM_MODE_INPUT 4'h0
`define GPEM_MODE_OUTPUT 4'h1
`define GPEM_MODE_DUAL_EDGE 4'h6
`define GPEM_MODE_SINGLE_EDGE 4'h9

// Reset values
`define GPEM_DATA_RESET 1'b0
`define GPEM_MODE_RESET 128'h0

// Vector base and step per pin
`define GPEM_VEC_BASE 8'h80
`define GPEM_VEC_STEP_SHIFT 2

// AXI responses
`define GPEM_RESP_OKAY 2'b00
`define GPEM_RESP_SLVERR 2'b10

`endif

/* File: sim/gpem_checker.sv */
// Checks of bus handshakes and interrupt outputs
`timescale 1ns/1ps
module gpem_checker(
   input wire aclk,
   input wire aresetn,
   input wire s_axi_awready,
   input wire s_axi_wready,
   input wire [1:0] s_axi_bresp,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire s_axi_rvalid,
   input wire s_axi_rready,
   input wire [31:0] pin_out,
   input wire irq_req,
   input wire [7:0] interrupt_vector_address
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // Answers stand until taken, busy slave refuses
   a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("bresp lost");
   a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("rdata lost");
   a_read_lat: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("late read");
   a_aw_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("aw taken");
   a_ar_refuse: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("ar taken");
   a_vec_form:
      assert property (irq_req ? interrupt_vector_address[7] && interrupt_vector_address[1:0] == 2'b00
         : interrupt_vector_address == 8'h00) else $error("bad vector");
   a_irq_hold:
      assert property ($fell(irq_req) |-> $past(s_axi_bvalid)) else $error("irq fell alone");
   a_data_keep:
      assert property ($changed(pin_out) |-> $past(s_axi_bvalid)) else $error("data moved alone");
endmodule

bind gpem_gpio_edge gpem_checker u_chk(.*);

/* File: sim/gpem_gpio_edge_tb.sv */
// Bench for the edge port block with mirrored clear logic
`timescale 1ns/1ps
`include "gpem_regs.vh"
module gpem_gpio_edge_tb;
   localparam [1:0] ok = `GPEM_RESP_OKAY;
   localparam [1:0] er = `GPEM_RESP_SLVERR;
   reg aclk = 1'b0;
   reg aresetn = 1'b0;
   reg [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
   reg [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
   reg [3:0] s_axi_wstrb = 4'hf;
   reg [31:0] s_axi_wdata = 32'h0, lvl = 32'h0;
   reg s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
   reg s_axi_bready = 1'b1, s_axi_rready = 1'b1;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq_req;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata, pin_in, pin_out, pin_oe_n;
   wire [7:0] interrupt_vector_address;
   integer fails = 0, n_compared = 0, cyc = 0, p;
   gpem_src u_src(.aclk, .lvl, .pin_in);
   gpem_gpio_edge u_dut(.*);
   // Clock and hang guard
   always #25 aclk = ~aclk;
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         fails = fails + 1;
         close_out;
      end
   end
   // Value compare
   task chk(input [31:0] got, input [31:0] exp);
      n_compared = n_compared + 1;
      if (got !== exp) begin
         fails = fails + 1;
         $display("ERROR %0t got %h want %h", $time, got, exp);
      end
   endtask
   // Bus write, both items offered together
   task wr(input [7:0] a, input [31:0] d, input [1:0] r);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      chk(s_axi_bresp, r);
   endtask
   // Bus read
   task rd(input [7:0] a, input [31:0] d, input [1:0] r);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      chk(s_axi_rdata, d);
      chk(s_axi_rresp, r);
   endtask
   // New pin levels, then time for pend and irq
   task pins(input [31:0] v);
      lvl <= v;
      repeat (4) @(posedge aclk);
   endtask
   // Edge pin with partner in edge mode, every port
   task t_mirror;
      for (p = 0; p < 4; p = p + 1) begin
         wr(p * 16 + 4, 32'h60000009, ok);
         pins(32'h1 << (p * 8));
         rd(p * 16 + 8, 32'h0, ok);
         pins(32'h0);
         rd(p * 16 + 8, 32'h1, ok);
         chk(interrupt_vector_address, 8'h80 + p * 32);
         chk(irq_req, 1'b1);
         wr(p * 16, 32'h1, ok);
         rd(p * 16 + 8, 32'h0, ok);
         rd(p * 16, 32'h0, ok);
         chk(irq_req, 1'b0);
      end
      $display("test mirror done");
   endtask
   // Edge pin whose partner is a plain input
   task t_solo;
      wr(8'h14, 32'h60, ok);
      pins(32'h200);
      chk(interrupt_vector_address, 8'ha4);
      wr(8'h10, 32'h2, ok);
      rd(8'h18, 32'h2, ok);
      rd(8'h10, 32'h2, ok);
      chk(pin_out, 32'h200);
      wr(8'h14, 32'h09000060, ok);
      wr(8'h10, 32'h0, ok);
      rd(8'h10, 32'h2, ok);
      wr(8'h10, 32'h2, ok);
      rd(8'h18, 32'h0, ok);
      pins(32'h0);
      rd(8'h18, 32'h2, ok);
      $display("test solo done");
   endtask
   // Mode kept from earlier test, unmapped and read-only places, output mode
   task t_bad;
      rd(8'h24, 32'h60000009, ok);
      rd(8'h40, 32'h0, er);
      wr(8'h44, 32'h1, er);
      wr(8'h18, 32'h0, ok);
      rd(8'h18, 32'h2, ok);
      wr(8'h34, 32'h1, ok);
      rd(8'h34, 32'h1, ok);
      chk(pin_oe_n, 32'hfeffffff);
      $display("test bad done");
   endtask
   // Counts and verdict
   task close_out;
      $display("compared %0d failed %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // Main sequence
   initial begin
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      chk(pin_oe_n, 32'hffffffff);
      t_mirror;
      t_solo;
      t_bad;
      close_out;
   end
endmodule

/* File: sim/gpem_src.sv */
// Signal sources standing on the port pins
`timescale 1ns/1ps
module gpem_src(
   input wire aclk,
   input wire [31:0] lvl,
   output reg [31:0] pin_in = 32'h0
);
   // idle partner pins just hold a level
   always @(posedge aclk) begin
      pin_in <= lvl;
   end
endmodule
